/* File: design/adcrt_top.sv */
// Purpose: conversion sequencing, parallel readout and master serial output
// Assumes: pins are asynchronous, core_result is on this clock
// Notes:   results pass through an 8-word buffer before readout
//
// Function
// - Busy lasts at most 1.45 us, except master serial read-after-convert.
// - Busy falls at least 10 ns after internal conversion ends.
// - Parallel result valid within 1.41 us of convert start falling.
// - Parallel data valid at least 20 ns before busy falls.
// - Bus data valid within 40 ns of request; released 2-15 ns after.
// - Read-during-convert frame starts about 560 ns after start; sends previous result.
// - Read-after-convert frame starts about 1.31 us after start.
// - First clock edge follows frame start by 3 ns, or 20 ns when divided.
// - Divided serial clock period at least 30, 60, 120, 240 ns.
// - Divided serial clock period at most 45, 90, 180, 360 ns.
// - Serial clock high and low phases meet per-setting minimums.
// - Frame stays asserted 5, 7, 35, 90 ns after last clock edge.
// - Read-after-convert busy spans transfer, bounded 2.25 to 7.30 us.
// - Busy falls about 25 ns after frame ends in read-after-convert.
// - Read-during-convert always uses undivided 30-45 ns serial clock.
// - Chip select low enables serial outputs within 10 ns.
// - Chip select high floats serial outputs within 10 ns.
// - Divide pins are inputs only in read-after-convert; driven only during a parallel bus request.
// - Each result is one 16-bit word, parallel or serial.
`timescale 1ns/1ns
`include "adcrt_cfg.svh"
module adcrt_top (
    input  logic                clk,
    input  logic                rst_b,
    input  logic                convert_start_n,
    input  logic                chip_select_n,
    input  logic                bus_request_n,
    input  logic                serial_parallel_select,
    input  logic                read_during_convert_select,
    input  logic                clock_source_select,
    input  logic [1:0]          serial_clock_divide_sel_in,
    output logic [1:0]          serial_clock_divide_sel_out,
    output logic                serial_clock_divide_sel_oe,
    input  adcrt_pkg::adcrt_word_t core_result,
    output logic                busy,
    output adcrt_pkg::adcrt_word_t data_out,
    output logic                data_oe,
    output logic                frame_sync,
    output logic                serial_data_clock,
    output logic                serial_result_out,
    output logic                serial_oe
);
    import adcrt_pkg::*;

    localparam logic [8:0] CONV_END = 9'(`ADCRT_CONV_CYC - 1);
    localparam logic [8:0] RDC_GO   = 9'(`ADCRT_RDC_SYNC_CYC - `ADCRT_SYNC_LAT - 1);
    localparam logic [8:0] RAC_GO   = 9'(`ADCRT_RAC_SYNC_CYC - `ADCRT_SYNC_LAT - 1);
    localparam logic [8:0] PAR_TAIL = 9'(`ADCRT_PAR_TAIL_CYC - 1);
    localparam logic [8:0] RAC_TAIL = 9'(`ADCRT_SYNC_BUSY_CYC - 2);
    localparam logic [5:0] HALF0    = 6'(`ADCRT_HALF0_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; enables are formed before the first flop so that
    // the output enables come straight off the second flop
    logic [7:0] pin_raw;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic       cnv_d;
    logic       start_fall;
    logic       ser_en;
    adcrt_mode_e mode_now;

    assign pin_raw = {~chip_select_n, ~bus_request_n & ~serial_parallel_select, convert_start_n,
                      serial_parallel_select, read_during_convert_select, clock_source_select,
                      serial_clock_divide_sel_in};

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pin_s1 <= `ADCRT_PIN_RST;
            pin_s2 <= `ADCRT_PIN_RST;
            cnv_d  <= 1'b1;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            cnv_d  <= pin_s2[5];
        end
    end

    assign start_fall = cnv_d & ~pin_s2[5];
    assign ser_en     = pin_s2[7];
    assign serial_oe  = pin_s2[7];
    assign data_oe    = pin_s2[6];
    assign serial_clock_divide_sel_oe = pin_s2[6];

    always_comb begin
        if (!pin_s2[4]) begin
            mode_now = MD_PAR;
        end else if (pin_s2[2]) begin
            mode_now = MD_SLV;
        end else if (pin_s2[3]) begin
            mode_now = MD_RDC;
        end else begin
            mode_now = MD_RAC;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result buffer; a full buffer refuses the next conversion start
    logic        f_in_valid;
    logic        f_in_ready;
    logic        f_out_valid;
    logic        f_out_ready;
    adcrt_word_t f_out_data;

    adcrt_fifo #(
        .WIDTH (`ADCRT_WORD_BITS),
        .DEPTH (`ADCRT_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (core_result),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    adcrt_cv_e   cv_state;
    adcrt_cv_e   next_cv_state;
    adcrt_mode_e mode;
    adcrt_mode_e next_mode;
    logic [8:0]  ccnt;
    logic [8:0]  next_ccnt;
    logic        next_busy;
    logic        ser_done;
    logic [8:0]  tail_end;

    assign tail_end = (mode == MD_RAC) ? RAC_TAIL : PAR_TAIL;

    always_comb begin
        next_cv_state = cv_state;
        next_ccnt     = ccnt;
        next_mode     = mode;
        next_busy     = busy;
        f_in_valid    = 1'b0;
        case (cv_state)
            CV_IDLE: begin
                if (start_fall && f_in_ready) begin
                    next_cv_state = CV_CONV;
                    next_ccnt     = '0;
                    next_mode     = mode_now;
                    next_busy     = 1'b1;
                end
            end
            CV_CONV: begin
                next_ccnt = ccnt + 9'h001;
                if (ccnt == CONV_END) begin
                    f_in_valid = 1'b1;
                    if (mode == MD_RAC && ser_en) begin
                        next_cv_state = CV_XFER;
                    end else begin
                        next_cv_state = CV_TAIL;
                        next_ccnt     = '0;
                    end
                end
            end
            CV_XFER: begin
                if (ccnt != 9'h1ff) begin
                    next_ccnt = ccnt + 9'h001;
                end
                if (ser_done) begin
                    next_cv_state = CV_TAIL;
                    next_ccnt     = '0;
                end
            end
            CV_TAIL: begin
                next_ccnt = ccnt + 9'h001;
                if (ccnt == tail_end) begin
                    next_cv_state = CV_IDLE;
                    next_busy     = 1'b0;
                end
            end
            default: begin
                next_cv_state = CV_IDLE;
                next_busy     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cv_state <= CV_IDLE;
            ccnt     <= '0;
            mode     <= MD_PAR;
            busy     <= 1'b0;
        end else begin
            cv_state <= next_cv_state;
            ccnt     <= next_ccnt;
            mode     <= next_mode;
            busy     <= next_busy;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readout: parallel takes every word, serial frames take one each
    adcrt_sr_e sr_state;
    logic      rdc_go;
    logic      rac_go;
    logic      par_pop;

    assign rdc_go = (cv_state == CV_CONV) && (mode == MD_RDC) && (ccnt == RDC_GO)
                    && ser_en && f_out_valid && (sr_state == SR_IDLE);
    assign rac_go = (cv_state == CV_XFER) && (ccnt == RAC_GO)
                    && f_out_valid && (sr_state == SR_IDLE);
    assign par_pop = (mode == MD_PAR) && f_out_valid;
    assign f_out_ready = par_pop | rdc_go | rac_go;

    adcrt_word_t next_data_out;
    logic [1:0]  next_div_out;

    always_comb begin
        next_data_out = data_out;
        next_div_out  = serial_clock_divide_sel_out;
        if (par_pop) begin
            next_data_out = f_out_data;
            next_div_out  = f_out_data[3:2];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            data_out                    <= '0;
            serial_clock_divide_sel_out <= 2'h0;
        end else begin
            data_out                    <= next_data_out;
            serial_clock_divide_sel_out <= next_div_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial engine: lead half, 16 clocks MSB first, trailing half
    adcrt_sr_e   next_sr_state;
    logic [5:0]  hcnt;
    logic [5:0]  next_hcnt;
    logic [5:0]  half_len;
    logic [5:0]  next_half_len;
    logic [3:0]  bitn;
    logic [3:0]  next_bitn;
    adcrt_word_t shreg;
    adcrt_word_t next_shreg;
    logic        next_sclk;
    logic        next_fsync;
    logic        next_sdo;
    logic        next_done;
    logic        half_hit;

    assign half_hit = (hcnt == half_len - 6'h01);

    always_comb begin
        next_sr_state = sr_state;
        next_hcnt     = hcnt + 6'h01;
        next_half_len = half_len;
        next_bitn     = bitn;
        next_shreg    = shreg;
        next_sclk     = serial_data_clock;
        next_fsync    = frame_sync;
        next_sdo      = serial_result_out;
        next_done     = 1'b0;
        case (sr_state)
            SR_IDLE: begin
                next_hcnt = '0;
                if (rdc_go || rac_go) begin
                    next_sr_state = SR_LEAD;
                    // Divider only honoured after conversion
                    next_half_len = rac_go ? HALF0 << pin_s2[1:0] : HALF0;
                    next_shreg    = f_out_data;
                    next_sdo      = f_out_data[15];
                    next_fsync    = 1'b1;
                    next_sclk     = 1'b0;
                    next_bitn     = '0;
                end
            end
            SR_LEAD: begin
                if (half_hit) begin
                    next_hcnt     = '0;
                    next_sclk     = 1'b1;
                    next_sr_state = SR_SHIFT;
                end
            end
            SR_SHIFT: begin
                if (half_hit) begin
                    next_hcnt = '0;
                    next_sclk = ~serial_data_clock;
                    if (serial_data_clock) begin
                        if (bitn == 4'hf) begin
                            next_sr_state = SR_HOLD;
                        end else begin
                            next_bitn  = bitn + 4'h1;
                            next_shreg = {shreg[14:0], 1'b0};
                            next_sdo   = shreg[14];
                        end
                    end
                end
            end
            SR_HOLD: begin
                if (half_hit) begin
                    next_hcnt     = '0;
                    next_sr_state = SR_IDLE;
                    next_fsync    = 1'b0;
                    next_sdo      = 1'b0;
                    next_done     = 1'b1;
                end
            end
            default: begin
                next_sr_state = SR_IDLE;
                next_fsync    = 1'b0;
                next_sclk     = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sr_state          <= SR_IDLE;
            hcnt              <= '0;
            half_len          <= 6'h04;
            bitn              <= '0;
            shreg             <= '0;
            serial_data_clock <= 1'b0;
            frame_sync        <= 1'b0;
            serial_result_out <= 1'b0;
            ser_done          <= 1'b0;
        end else begin
            sr_state          <= next_sr_state;
            hcnt              <= next_hcnt;
            half_len          <= next_half_len;
            bitn              <= next_bitn;
            shreg             <= next_shreg;
            serial_data_clock <= next_sclk;
            frame_sync        <= next_fsync;
            serial_result_out <= next_sdo;
            ser_done          <= next_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    localparam int BUSY_LIM = `ADCRT_BUSY_MAX_CYC - `ADCRT_SYNC_LAT;
    logic [10:0] bcnt;
    logic [5:0]  lvl_cnt;
    logic [4:0]  edge_cnt;
    logic [10:0] rac_lim;

    always_comb begin
        case (half_len)
            6'h04:   rac_lim = 11'(`ADCRT_RAC_BUSY0_CYC - `ADCRT_SYNC_LAT);
            6'h08:   rac_lim = 11'(`ADCRT_RAC_BUSY1_CYC - `ADCRT_SYNC_LAT);
            6'h10:   rac_lim = 11'(`ADCRT_RAC_BUSY2_CYC - `ADCRT_SYNC_LAT);
            default: rac_lim = 11'(`ADCRT_RAC_BUSY3_CYC - `ADCRT_SYNC_LAT);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bcnt     <= '0;
            lvl_cnt  <= '0;
            edge_cnt <= '0;
        end else begin
            bcnt     <= busy ? bcnt + 11'h001 : 11'h000;
            lvl_cnt  <= (serial_data_clock != next_sclk || (next_fsync && !frame_sync)) ? 6'h01 : lvl_cnt + 6'h01;
            edge_cnt <= !frame_sync ? 5'h00 : edge_cnt + 5'(next_sclk & ~serial_data_clock);
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    busy_max_a: assert property (busy && mode != MD_RAC |-> bcnt < 11'(BUSY_LIM))
        else $error("busy too long");
    eoc_busy_a: assert property (f_in_valid |-> ##1 busy [*3])
        else $error("busy fell too soon after conversion");
    par_data_a: assert property (f_in_valid && mode == MD_PAR |-> ##2 data_out == $past(core_result, 2))
        else $error("parallel result not presented");
    data_lead_a: assert property ($fell(busy) && mode == MD_PAR |-> data_out == $past(data_out, 5))
        else $error("data changed near busy fall");
    bus_release_a: assert property ($rose(bus_request_n) |-> ##[1:2] !data_oe)
        else $error("bus not released");
    rdc_frame_a: assert property ($rose(frame_sync) && cv_state == CV_CONV |-> ccnt == RDC_GO + 9'h001)
        else $error("read-during-convert frame misplaced");
    rac_frame_a: assert property ($rose(frame_sync) && cv_state == CV_XFER |-> ccnt == RAC_GO + 9'h001)
        else $error("read-after-convert frame misplaced");
    lead_gap_a: assert property ($rose(frame_sync) |-> !serial_data_clock [*4])
        else $error("first clock edge too early");
    lead_div_a: assert property ($rose(frame_sync) && half_len > HALF0 |-> !serial_data_clock [*5])
        else $error("divided first edge too early");
    sclk_half_a: assert property (sr_state == SR_SHIFT && serial_data_clock != $past(serial_data_clock)
                                  |-> lvl_cnt == 6'h01 && $past(lvl_cnt) == half_len)
        else $error("serial clock phase length wrong");
    rdc_undiv_a: assert property ($rose(frame_sync) && mode == MD_RDC |-> half_len == HALF0)
        else $error("divided clock in read-during-convert");
    frame_tail_a: assert property (sr_state == SR_HOLD && $past(sr_state) == SR_SHIFT
                                   |-> frame_sync [*2])
        else $error("frame dropped too soon");
    rac_width_a: assert property (busy && mode == MD_RAC |-> bcnt < rac_lim)
        else $error("read-after-convert busy too long");
    rac_drop_a: assert property ($fell(frame_sync) && mode == MD_RAC && cv_state == CV_XFER
                                 |-> busy [*7] ##1 !busy)
        else $error("busy fall after frame misplaced");
    cs_on_a: assert property ($fell(chip_select_n) |-> ##[1:2] serial_oe)
        else $error("serial outputs not enabled");
    cs_off_a: assert property ($rose(chip_select_n) |-> ##[1:2] !serial_oe)
        else $error("serial outputs not floated");
    div_hiz_a: assert property (pin_s2[4] |-> !serial_clock_divide_sel_oe)
        else $error("divide pins driven in serial mode");
    word_len_a: assert property ($fell(frame_sync) |-> $past(edge_cnt) == 5'h10)
        else $error("serial word not 16 bits");

    par_conv_c: cover property (f_in_valid && mode == MD_PAR ##[1:20] $fell(busy));
    rdc_frame_c: cover property ($rose(frame_sync) && mode == MD_RDC);
    rac_slow_c: cover property ($rose(frame_sync) && half_len == 6'h20);
    full_c: cover property (start_fall && !f_in_ready);
endmodule

/* File: design/adcrt_cfg.svh */
// Purpose: constants for the conversion and readout timing block
// Assumes: 250 MHz core clock
// Notes:   times in their own unit, cycle counts derived below
`ifndef ADCRT_CFG_SVH
`define ADCRT_CFG_SVH

`define ADCRT_CLK_NS          4
`define ADCRT_WORD_BITS       16
`define ADCRT_FIFO_DEPTH      8
`define ADCRT_SYNC_LAT        3

`define ADCRT_T_CONV_NS       1280
`define ADCRT_T_BUSY_MAX_US   1.45
`define ADCRT_T_DATA_VAL_US   1.41
`define ADCRT_T_EOC_BUSY_NS   10
`define ADCRT_T_DATA_BUSY_NS  20
`define ADCRT_T_PAR_TAIL_NS   32
`define ADCRT_T_RDC_SYNC_NS   560
`define ADCRT_T_RAC_SYNC_US   1.31
`define ADCRT_T_SYNC_BUSY_NS  25
`define ADCRT_T_HALF0_NS      16
`define ADCRT_T_RAC_BUSY0_US  2.25
`define ADCRT_T_RAC_BUSY1_US  3.00
`define ADCRT_T_RAC_BUSY2_US  4.40
`define ADCRT_T_RAC_BUSY3_US  7.30

`define ADCRT_US2NS(t)        $rtoi((t) * 1000.0 + 0.5)
`define ADCRT_CONV_CYC        (`ADCRT_T_CONV_NS / `ADCRT_CLK_NS)
`define ADCRT_BUSY_MAX_CYC    (`ADCRT_US2NS(`ADCRT_T_BUSY_MAX_US) / `ADCRT_CLK_NS)
`define ADCRT_DATA_VAL_CYC    (`ADCRT_US2NS(`ADCRT_T_DATA_VAL_US) / `ADCRT_CLK_NS)
`define ADCRT_EOC_BUSY_CYC    ((`ADCRT_T_EOC_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_DATA_BUSY_CYC   ((`ADCRT_T_DATA_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_PAR_TAIL_CYC    ((`ADCRT_T_PAR_TAIL_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_RDC_SYNC_CYC    (`ADCRT_T_RDC_SYNC_NS / `ADCRT_CLK_NS)
`define ADCRT_RAC_SYNC_CYC    (`ADCRT_US2NS(`ADCRT_T_RAC_SYNC_US) / `ADCRT_CLK_NS)
`define ADCRT_SYNC_BUSY_CYC   ((`ADCRT_T_SYNC_BUSY_NS + `ADCRT_CLK_NS - 1) / `ADCRT_CLK_NS)
`define ADCRT_HALF0_CYC       (`ADCRT_T_HALF0_NS / `ADCRT_CLK_NS)
`define ADCRT_RAC_BUSY0_CYC   (`ADCRT_US2NS(`ADCRT_T_RAC_BUSY0_US) / `ADCRT_CLK_NS)
`define ADCRT_RAC_BUSY1_CYC   (`ADCRT_US2NS(`ADCRT_T_RAC_BUSY1_US) / `ADCRT_CLK_NS)
`define ADCRT_RAC_BUSY2_CYC   (`ADCRT_US2NS(`ADCRT_T_RAC_BUSY2_US) / `ADCRT_CLK_NS)
`define ADCRT_RAC_BUSY3_CYC   (`ADCRT_US2NS(`ADCRT_T_RAC_BUSY3_US) / `ADCRT_CLK_NS)
`define ADCRT_PIN_RST         8'h20

`endif

/* File: design/adcrt_pkg.sv */
// Purpose: types for the conversion and readout timing block
// Assumes: constants come from the cfg header
// Notes:   state codes are Gray along the usual path
`include "adcrt_cfg.svh"
package adcrt_pkg;
    typedef logic [`ADCRT_WORD_BITS-1:0] adcrt_word_t;
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_CONV = 2'b01,
        CV_XFER = 2'b11,
        CV_TAIL = 2'b10
    } adcrt_cv_e;
    typedef enum logic [1:0] {
        SR_IDLE  = 2'b00,
        SR_LEAD  = 2'b01,
        SR_SHIFT = 2'b11,
        SR_HOLD  = 2'b10
    } adcrt_sr_e;
    typedef enum logic [1:0] {
        MD_PAR = 2'b00,
        MD_RDC = 2'b01,
        MD_RAC = 2'b11,
        MD_SLV = 2'b10
    } adcrt_mode_e;
endpackage

/* File: design/adcrt_fifo.sv */
// Purpose: result buffer between conversion and readout
// Assumes: DEPTH is a power of two, pointers wrap freely
// Notes:   show-ahead output, count gives honest full and empty
`timescale 1ns/1ns
`include "adcrt_cfg.svh"
module adcrt_fifo #(
    parameter int WIDTH = `ADCRT_WORD_BITS,
    parameter int DEPTH = `ADCRT_FIFO_DEPTH
) (
    input  logic             clk,
    input  logic             rst_b,
    input  logic             in_valid,
    output logic             in_ready,
    input  logic [WIDTH-1:0] in_data,
    output logic             out_valid,
    input  logic             out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage carries no reset, only the pointers matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

/* File: tb/adcrt_host.sv */
// Purpose: host end of the master serial link
// Assumes: serial outputs enabled by chip select
// Notes:   samples on rising serial clock, as a real receiver
`timescale 1ns/1ns
module adcrt_host (
    input  logic        clk,
    input  logic        frame_sync,
    input  logic        serial_data_clock,
    input  logic        serial_result_out,
    input  logic        serial_oe,
    output logic [15:0] word,
    output int          hi_len
);
    logic prev = 1'b0;
    int   run  = 0;
    always @(posedge clk) begin
        prev <= serial_data_clock;
        run  <= serial_data_clock ? run + 1 : 0;
        if (serial_oe && frame_sync && serial_data_clock && !prev) begin
            word <= {word[14:0], serial_result_out};
        end
        if (!serial_data_clock && prev) begin
            hi_len <= run;
        end
    end
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for conversion and readout timing
// Assumes: external clock mode only checked for suppressed frames
// Notes:   serial cases first, so the buffer starts empty for them
`timescale 1ns/1ns
module tb;
    import adcrt_pkg::*;
    logic        clk = 1'b0, rst_b = 1'b0, cs_n = 1'b1, start_n = 1'b1, req_n = 1'b1;
    logic        ser = 1'b1, rdc = 1'b0, ext = 1'b0, busy, doe, fs, sclk, sdo, soe, dsel_oe;
    logic [1:0]  div = 2'h0, dsel;
    adcrt_word_t res = 16'h0000, word, dout;
    int          hi_len, width, n, fail_count = 0, checked = 0;
    int          pmin [4] = '{30, 60, 120, 240};
    int          pmax [4] = '{45, 90, 180, 360};
    int          bmax [4] = '{562, 750, 1100, 1825};
    always #2 clk = ~clk;
    adcrt_top dut_u (.clk(clk), .rst_b(rst_b), .convert_start_n(start_n), .chip_select_n(cs_n),
        .bus_request_n(req_n), .serial_parallel_select(ser), .read_during_convert_select(rdc),
        .clock_source_select(ext), .serial_clock_divide_sel_in(div), .serial_clock_divide_sel_out(dsel),
        .serial_clock_divide_sel_oe(dsel_oe), .core_result(res), .busy(busy), .data_out(dout),
        .data_oe(doe), .frame_sync(fs), .serial_data_clock(sclk), .serial_result_out(sdo),
        .serial_oe(soe));
    adcrt_host host_u (.clk(clk), .frame_sync(fs), .serial_data_clock(sclk),
        .serial_result_out(sdo), .serial_oe(soe), .word(word), .hi_len(hi_len));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        checked++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("ERROR t=%0t %0d outside %0d..%0d", $time, v, lo, hi);
        end
    endtask
    // Bounded wait; a run-out ends the run as a mismatch
    task automatic await(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
            if (k > lim) begin
                fail_count++;
                tally_and_finish;
            end
        end while (s !== v);
    endtask
    task automatic convert(input adcrt_word_t r);
        @(posedge clk);
        res     <= r;
        start_n <= 1'b0;
        repeat (3) @(posedge clk);
        start_n <= 1'b1;
        await(busy, 1'b1, 20, n);
        await(busy, 1'b0, 3000, width);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        await(soe, 1'b1, 3, n);
        for (int d = 0; d < 4; d++) begin
            @(posedge clk);
            div <= d[1:0];
            convert(16'ha5c0 | 16'(d));
            chk(word, 16'ha5c0 | 16'(d));
            chk_rng(hi_len * 8, pmin[d], pmax[d]);
            chk_rng(width, 320, bmax[d]);
        end
        @(posedge clk);
        rdc <= 1'b1;
        convert(16'h1234);
        convert(16'hbeef);
        chk(word, 16'h1234);
        chk_rng(hi_len * 8, 30, 45);
        chk_rng(width, 323, 362);
        chk(dsel_oe, 1'b0);
        @(posedge clk);
        ext <= 1'b1;
        convert(16'h5a5a);
        chk(word, 16'h1234);
        chk_rng(width, 323, 362);
        @(posedge clk);
        cs_n <= 1'b1;
        await(soe, 1'b0, 3, n);
        @(posedge clk);
        ser <= 1'b0;
        ext <= 1'b0;
        convert(16'h0ff4);
        chk(dout, 16'h0ff4);
        chk_rng(width, 323, 362);
        @(posedge clk);
        req_n <= 1'b0;
        await(doe, 1'b1, 10, n);
        chk(dout, 16'h0ff4);
        chk(dsel, 2'h1);
        chk(dsel_oe, 1'b1);
        @(posedge clk);
        req_n <= 1'b1;
        await(doe, 1'b0, 4, n);
        chk(dsel_oe, 1'b0);
        tally_and_finish;
    end
endmodule
